// ===== design/tick_crossing.sv
// Crossing stage: carries one event into the slow tick domain
`timescale 1ns/1ps
module tick_crossing
    import wdog_pkg::*;
(
    input  wire logic   pclk,       // System clock
    input  wire logic   presetn,    // Async reset, active low
    crossing_if.unit    xfer        // Request, tick and completion
);
    logic [1:0] stage;

    // ========================================
    // Busy window and tick counting
    // A request while busy is dropped: the stage holds one event only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer.busy <= 1'b0;
            stage     <= 2'h0;
        end else if (!xfer.busy) begin
            xfer.busy <= xfer.req;
            stage     <= 2'h0;
        end else if (xfer.tick) begin
            if (stage == SYNC_TICKS - 2'h1) begin
                xfer.busy <= 1'b0;
            end
            stage <= stage + 2'h1;
        end
    end

    // Lands on the third tick, two to three tick periods after request
    assign xfer.done = xfer.busy && xfer.tick && (stage == SYNC_TICKS - 2'h1);
endmodule

// ===== design/window_watchdog_timer.sv
// Window watchdog timer with protected configuration, lock and APB slave
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module window_watchdog_timer
    import wdog_pkg::*;
(
    input  wire logic        pclk,                       // System clock, 100 MHz
    input  wire logic        presetn,                    // Async reset, active low
    input  wire logic        psel,                       // APB select
    input  wire logic        penable,                    // APB enable
    input  wire logic        pwrite,                     // APB direction
    input  wire logic [11:0] paddr,                      // APB byte address
    input  wire logic [31:0] pwdata,                     // APB write data
    output logic      [31:0] prdata,                     // APB read data
    output logic             pready,                     // APB ready
    output logic             pslverr,                    // APB error, unmapped only
    input  wire logic [7:0]  boot_config_fuse,           // Boot value of watchdog_config
    input  wire logic        io_unlock_key,              // Key written to CPU key register
    input  wire logic        cpu_instr_retired,          // One CPU instruction completed
    input  wire logic        watchdog_clear_instruction, // Clear instruction executed
    input  wire logic        debug_halted,               // CPU halted in debug
    input  wire logic        debug_mode,                 // Debugger attached
    input  wire logic        slow_osc_tick,              // 1 kHz tick, one pclk wide
    output logic             system_reset_request        // To reset controller
);
    import wdog_pkg::*;

    // ========================================
    // Declarations
    logic [7:0]  watchdog_config;    // Software view
    logic        lock;
    logic        boot_done;
    logic [2:0]  unlock_left;
    logic [3:0]  open_timeout;       // Active in tick domain
    logic [3:0]  closed_timeout;
    logic [13:0] count;
    logic        in_closed;
    logic        apb_access;
    logic        apb_write;
    logic        addr_config;
    logic        addr_state;
    logic        gate_open;
    logic        config_write_ok;
    logic [13:0] open_len;
    logic [13:0] closed_len;
    logic [13:0] next_count;
    logic        enabled;
    logic        window_mode;

    // ========================================
    // Tick-domain event terms and lock requests
    logic        step;               // Tick that counts
    logic        clear_open;         // Clear lands outside the closed phase
    logic        clear_shut;         // Clear lands inside the closed phase
    logic        closed_over;        // Closed phase runs out on this tick
    logic        open_over;          // Open phase runs out on this tick
    logic        lock_set;           // Software sets the lock
    logic        lock_clear;         // Debugger clears the lock

    crossing_if clear_x ();
    crossing_if cfg_x ();

    // ========================================
    // Code to tick length, doubling from 8
    function automatic logic [13:0] code_ticks(input logic [3:0] code);
        logic [13:0] len;
        len = MAX_TICKS;
        if (code != CODE_OFF && code <= CODE_MAX) begin
            len = BASE_TICKS << (code - 4'h1);
        end
        return len;
    endfunction

    assign open_len    = code_ticks(open_timeout);
    assign closed_len  = code_ticks(closed_timeout);
    assign enabled     = open_timeout != CODE_OFF;
    assign window_mode = closed_timeout != CODE_OFF;
    assign next_count  = count + 14'h0001;

    // ========================================
    // APB decode; one wait state, write lands on the pready edge
    assign apb_access  = psel && penable && pready;
    assign apb_write   = apb_access && pwrite;
    assign addr_config = paddr == ADDR_CONFIG;
    assign addr_state  = paddr == ADDR_STATE;

    // Ready: one wait state, one cycle wide, so a held request is answered every second cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // Error only outside the two registers; protected misses stay silent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && penable && !pready && !addr_config && !addr_state;
        end
    end

    // Read data, zero outside the answer cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                if (addr_config) begin
                    prdata[7:0] <= watchdog_config;
                end else if (addr_state) begin
                    prdata[LOCK_BIT] <= lock;
                    prdata[BUSY_BIT] <= cfg_x.busy;
                end
            end
        end
    end

    // ========================================
    // Protected write gate: open for four instructions after the key
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_left <= 3'h0;
        end else if (io_unlock_key) begin
            unlock_left <= UNLOCK_COUNT;
        end else if (cpu_instr_retired && unlock_left != 3'h0) begin
            unlock_left <= unlock_left - 3'h1;
        end
    end

    assign gate_open = unlock_left != 3'h0;
    // Writes during busy are dropped so a transfer in flight is never torn
    assign config_write_ok = apb_write && addr_config && gate_open && !lock
                             && !cfg_x.busy;

    // ========================================
    // Software config and lock; fuse captured at the first edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_config <= CONFIG_RESET;
        end else if (!boot_done) begin
            watchdog_config <= boot_config_fuse;
        end else if (config_write_ok) begin
            watchdog_config <= pwdata[7:0];
        end
    end

    // Boot marker: one edge of fuse load, then software owns the config
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_done <= 1'b0;
        end else begin
            boot_done <= 1'b1;
        end
    end

    // ========================================
    // Lock: software may only set it; the debugger alone may clear it
    assign lock_set   = apb_write && addr_state && gate_open && pwdata[LOCK_BIT];
    assign lock_clear = apb_write && addr_state && gate_open && !pwdata[LOCK_BIT]
                        && debug_mode;

    // Set is tested first, so a set never loses to a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock <= 1'b0;
        end else if (!boot_done) begin
            lock <= boot_config_fuse[OPEN_LSB +: 4] != CODE_OFF;
        end else if (lock_set) begin
            lock <= 1'b1;
        end else if (lock_clear) begin
            lock <= 1'b0;
        end
    end

    // ========================================
    // Crossings into the tick domain
    // Boot load also crosses so the active copy follows the fuse
    assign cfg_x.tick   = slow_osc_tick;
    assign cfg_x.req    = config_write_ok || !boot_done;
    assign clear_x.tick = slow_osc_tick;
    assign clear_x.req  = watchdog_clear_instruction;

    tick_crossing cfg_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .xfer    (cfg_x)
    );

    tick_crossing clear_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .xfer    (clear_x)
    );

    // ========================================
    // Active config in the tick domain
    // Open length: only replaced on a landing, never mid-crossing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_timeout <= CODE_OFF;
        end else if (cfg_x.done) begin
            open_timeout <= watchdog_config[OPEN_LSB +: 4];
        end
    end

    // Closed length follows the same landing, so both fields switch together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            closed_timeout <= CODE_OFF;
        end else if (cfg_x.done) begin
            closed_timeout <= watchdog_config[CLOSED_LSB +: 4];
        end
    end

    // ========================================
    // Window phase, one-hot
    // Idle follows a halt, a disable or a landing: it counts like open,
    // and a clear there arms the first closed phase
    typedef enum logic [2:0] {
        PHASE_IDLE   = 3'b001,                          // Fresh start, no window yet
        PHASE_OPEN   = 3'b010,                          // Clear allowed
        PHASE_CLOSED = 3'b100                           // Clear forbidden
    } phase_t;

    phase_t phase;
    phase_t next_phase;

    // ========================================
    // Tick-domain events, named once so every process agrees
    // No sleep gating here: only the tick stopping, a debug halt, a disable or a config landing stops the count
    assign step        = slow_osc_tick && enabled && !debug_halted && !cfg_x.done;
    assign in_closed   = phase == PHASE_CLOSED;
    assign clear_open  = clear_x.done && !in_closed;
    assign clear_shut  = clear_x.done && in_closed;
    assign closed_over = in_closed && next_count >= closed_len;
    assign open_over   = !in_closed && next_count >= open_len;

    // Phase step; a clear in closed keeps the phase, the request is sticky
    always_comb begin
        next_phase = phase;
        if (debug_halted || cfg_x.done || !enabled) begin
            next_phase = PHASE_IDLE;
        end else if (step) begin
            unique case (phase)
                PHASE_IDLE, PHASE_OPEN: begin
                    if (clear_open && window_mode) begin
                        next_phase = PHASE_CLOSED;
                    end else begin
                        next_phase = PHASE_OPEN;
                    end
                end
                PHASE_CLOSED: begin
                    if (closed_over) begin
                        next_phase = PHASE_OPEN;
                    end
                end
                // Stray code from an upset: restart cleanly
                default: begin
                    next_phase = PHASE_IDLE;
                end
            endcase
        end
    end

    // Phase register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= PHASE_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // ========================================
    // Tick counter; zero while off, halted or reloading
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 14'h0000;
        end else if (debug_halted || cfg_x.done || !enabled) begin
            count <= 14'h0000;
        end else if (step) begin
            if (clear_open || closed_over) begin
                count <= 14'h0000;
            end else begin
                count <= next_count;
            end
        end
    end

    // ========================================
    // Reset request, sticky until device reset
    // A clear landing with the config is ignored, so only step gates it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_reset_request <= 1'b0;
        end else if (step) begin
            if (clear_shut) begin
                system_reset_request <= 1'b1;
            end else if (!clear_x.done && open_over) begin
                system_reset_request <= 1'b1;
            end
        end
    end
endmodule

// ===== shared/crossing_if.sv
// Interface between the watchdog top and its slow-tick crossing stage
`timescale 1ns/1ps
interface crossing_if;
    logic tick;     // Slow oscillator tick, one pclk wide
    logic req;      // Start of a transfer
    logic busy;     // Transfer in flight
    logic done;     // Transfer lands, coincident with a tick

    modport unit (input tick, input req, output busy, output done);
    modport user (output tick, output req, input busy, input done);
endinterface

// ===== shared/wdog_pkg.sv
// Package: register map, field layout and timing constants of the watchdog
package wdog_pkg;
    // ========================================
    // Register indices and byte addresses
    localparam logic [3:0]  REG_IDX_CONFIG  = 4'h0;    // watchdog_config index
    localparam logic [3:0]  REG_IDX_STATE   = 4'h1;    // watchdog_state index
    localparam logic [11:0] ADDR_CONFIG     = {6'h00, REG_IDX_CONFIG, 2'b00};
    localparam logic [11:0] ADDR_STATE      = {6'h00, REG_IDX_STATE, 2'b00};
    // ========================================
    // Field positions
    localparam int OPEN_LSB    = 0;                    // open_timeout code, bits 3:0
    localparam int CLOSED_LSB  = 4;                    // closed_timeout code, bits 7:4
    localparam int LOCK_BIT    = 7;                    // lock bit in watchdog_state
    localparam int BUSY_BIT    = 0;                    // clock_crossing_pending bit
    // ========================================
    // Values after reset and codes
    localparam logic [7:0]  CONFIG_RESET    = 8'h00;   // replaced by fuse after release
    localparam logic [3:0]  CODE_OFF        = 4'h0;
    localparam logic [3:0]  CODE_MAX        = 4'hB;    // 8192 ticks
    localparam logic [13:0] BASE_TICKS      = 14'h0008;
    localparam logic [13:0] MAX_TICKS       = 14'h2000;
    // ========================================
    // Timing
    localparam int  CLK_PERIOD_NS   = 10;              // pclk at 100 MHz
    localparam int  UNLOCK_INSTRS   = 4;               // protected write window
    localparam logic [2:0] UNLOCK_COUNT = 3'(UNLOCK_INSTRS);
    localparam logic [1:0] SYNC_TICKS   = 2'h3;        // ticks until a crossing lands
endpackage

// ===== sim/cpu_model.sv
// CPU stand-in that issues clear instructions and the unlock key
`timescale 1ns/1ps
module cpu_model
(
    input  wire logic pclk,                       // System clock
    input  wire logic do_clear,                   // Issue one clear
    input  wire logic do_key,                     // Write the unlock key
    input  wire logic lag,                        // Slow core, clear one cycle late
    output logic      watchdog_clear_instruction, // Clear pulse
    output logic      io_unlock_key,              // Key pulse
    output logic      cpu_instr_retired           // One per clear instruction
);
    logic held; // Clear parked for slow mode
    // ====
    // Key store not counted as retired, so the four-instruction window stays whole
    always_ff @(posedge pclk) begin
        held                       <= do_clear & lag;
        watchdog_clear_instruction <= (do_clear & ~lag) | held;
        io_unlock_key              <= do_key;
        cpu_instr_retired          <= (do_clear & ~lag) | held;
    end
endmodule

// ===== sim/tb_top.sv
// Testbench: bus master, boot fuse, fast tick and CPU model
`timescale 1ns/1ps
module tb_top;
    import wdog_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_req;
    logic        tick, do_clear, do_key, lag, wclr, key, ret;
    logic        dbg_halt, dbg_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  fuse;
    logic [33:0] e;
    logic [33:0] exp_q[$];
    int          bad_count, compares, tcnt;
    // ====
    // Clock, and a tick every 20 cycles to keep the run short
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        tcnt <= (tcnt == 19) ? 0 : tcnt + 1;
        tick <= (tcnt == 19);
    end
    window_watchdog_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boot_config_fuse(fuse), .io_unlock_key(key),
        .cpu_instr_retired(ret), .watchdog_clear_instruction(wclr), .debug_halted(dbg_halt),
        .debug_mode(dbg_mode), .slow_osc_tick(tick), .system_reset_request(rst_req));
    cpu_model cpu (.pclk(pclk), .do_clear(do_clear), .do_key(do_key), .lag(lag),
        .watchdog_clear_instruction(wclr), .io_unlock_key(key), .cpu_instr_retired(ret));
    // ====
    // Checking
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rq(input logic v);
        chk({32'h0000_0000, rst_req}, {32'h0000_0000, v});
    endtask
    // Monitor takes the oldest note at each read answer; top bit means error only
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            if (e[33]) chk({pslverr, 32'h0000_0000}, {e[32], 32'h0000_0000});
            else chk({pslverr, prdata}, e[32:0]);
        end
    end
    // ====
    // Bus and CPU tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [33:0] x);
        int n;
        n = 0;
        if (!w) exp_q.push_back(x);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 20) begin
            bad_count++;
            $display("[FAIL] t=%0t pready got %h exp %h", $time, 1'b0, 1'b1);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0000_0000, {2'b00, v});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v, '0);
    endtask
    task automatic unlock();
        do_key <= 1'b1;
        @(posedge pclk);
        do_key <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic clear(input logic l);
        lag      <= l;
        do_clear <= 1'b1;
        @(posedge pclk);
        do_clear <= 1'b0;
        @(posedge pclk);
    endtask
    // A crossing lands by the third tick, 60 cycles; this covers it
    task automatic settle();
        repeat (100) @(posedge pclk);
    endtask
    task automatic wait_rq(input int lim);
        int i;
        i = 0;
        while (rst_req !== 1'b1 && i < lim) begin
            i++;
            @(posedge pclk);
        end
        rq(1'b1);
    endtask
    task automatic boot(input logic [7:0] f);
        presetn <= 1'b0;
        fuse    <= f;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        settle();
    endtask
    task tally_and_finish;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ====
    // Watchdog of the bench itself
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        tally_and_finish;
    end
    // ====
    // Main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, do_clear, do_key, lag, tick} = '0;
        {dbg_halt, dbg_mode} = '0;
        {paddr, pwdata, fuse, bad_count, compares, tcnt} = '0;
        void'($urandom(32'h979c95ee));
        boot(8'h00);
        rd(ADDR_CONFIG, 32'h0000_0000);
        wr(ADDR_CONFIG, $urandom | 32'h0000_0001);
        rd(ADDR_CONFIG, 32'h0000_0000);
        apb(1'b0, 12'h008, 32'h0000_0000, {2'b11, 32'h0000_0000});
        $display("boot and protection test done");
        unlock();
        wr(ADDR_CONFIG, 32'h0000_0001);
        rd(ADDR_STATE, 32'h0000_0001);
        settle();
        rd(ADDR_STATE, 32'h0000_0000);
        rd(ADDR_CONFIG, 32'h0000_0001);
        repeat (60) @(posedge pclk);
        rq(1'b0);
        wait_rq(200);
        $display("normal timeout test done");
        boot(8'h01);
        rd(ADDR_CONFIG, 32'h0000_0001);
        rd(ADDR_STATE, 32'h0000_0080);
        repeat (6) begin
            clear(1'b0);
            repeat (78) @(posedge pclk);
        end
        rq(1'b0);
        unlock();
        wr(ADDR_CONFIG, 32'h0000_0002);
        rd(ADDR_CONFIG, 32'h0000_0001);
        unlock();
        wr(ADDR_STATE, 32'h0000_0000);
        rd(ADDR_STATE, 32'h0000_0080);
        dbg_mode <= 1'b1;
        unlock();
        wr(ADDR_STATE, 32'h0000_0000);
        rd(ADDR_STATE, 32'h0000_0000);
        dbg_mode <= 1'b0;
        dbg_halt <= 1'b1;
        repeat (200) @(posedge pclk);
        rq(1'b0);
        dbg_halt <= 1'b0;
        wait_rq(200);
        $display("clear and lock test done");
        boot(8'h00);
        unlock();
        wr(ADDR_CONFIG, 32'h0000_0013);
        settle();
        clear(1'b0);
        repeat (4) @(posedge pclk);
        clear(1'b1);
        repeat (100) @(posedge pclk);
        rq(1'b0);
        clear(1'b0);
        wait_rq(120);
        $display("window test done");
        tally_and_finish;
    end
endmodule

// ===== sim/wdog_sva.sv
// Checker: port-level properties of the watchdog
`timescale 1ns/1ps
module wdog_sva
    import wdog_pkg::*;
(
    input wire logic        pclk,                 // Clock
    input wire logic        presetn,              // Reset, active low
    input wire logic        psel,                 // Select
    input wire logic        penable,              // Enable
    input wire logic        pwrite,               // Direction
    input wire logic [11:0] paddr,                // Address
    input wire logic [31:0] prdata,               // Read data
    input wire logic        pready,               // Ready
    input wire logic        pslverr,              // Error
    input wire logic        slow_osc_tick,        // Slow tick
    input wire logic        system_reset_request  // Reset request
);
    // ====
    // One domain, so clock and reset are given once
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====
    // Bus answer
    wait_state_a: assert property (
        (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("bus wait state wrong");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    idle_quiet_a: assert property (!psel |-> !pready && !pslverr)
        else $error("answer without select");
    mapped_ok_a: assert property (
        pready && (paddr == ADDR_CONFIG || paddr == ADDR_STATE) |-> !pslverr)
        else $error("error on mapped register");
    state_bits_a: assert property (
        pready && !pwrite && paddr == ADDR_STATE |-> prdata[6:1] == 6'h00)
        else $error("unused status bits set");
    high_bits_a: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("read data above byte set");
    // ====
    // Reset request
    request_sticky_a: assert property (system_reset_request |=> system_reset_request)
        else $error("reset request dropped");
    request_tick_a: assert property (
        $rose(system_reset_request) |-> $past(slow_osc_tick) || $past(slow_osc_tick, 2))
        else $error("reset request off tick");
    boot_quiet_a: assert property ($rose(presetn) |-> !system_reset_request [*8])
        else $error("reset request right after boot");
endmodule

bind window_watchdog_timer wdog_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_osc_tick(slow_osc_tick),
    .system_reset_request(system_reset_request));
